// >>> verilog/mmpc_pkg.sv
package mmpc_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] MMPC_OFS_RAM_POS   = 8'h00;
  localparam logic [7:0] MMPC_OFS_REG_POS   = 8'h04;
  localparam logic [7:0] MMPC_OFS_EE_POS    = 8'h08;
  localparam logic [7:0] MMPC_OFS_SYS_OPT   = 8'h0C;
  localparam logic [7:0] MMPC_OFS_TEST_A    = 8'h10;
  localparam logic [7:0] MMPC_OFS_TEST_B    = 8'h14;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         MMPC_BASE_HI       = 7;
  localparam int         MMPC_BASE_LO       = 3;
  localparam int         MMPC_BIT0          = 0;
  localparam int         MMPC_FLASH_UPPER_HALF_ONLY_BIT     = 1;
  localparam int         MMPC_STR_HI        = 3;
  localparam int         MMPC_STR_LO        = 2;
  localparam logic [7:0] MMPC_RAM_POS_RST   = 8'h09;
  localparam logic [7:0] MMPC_REG_POS_RST   = 8'h00;
  localparam logic [1:0] MMPC_STR_RST       = 2'h3;
  localparam logic [7:0] MMPC_TEST_A_VAL    = 8'h00;
  localparam logic [7:0] MMPC_TEST_B_VAL    = 8'h00;

  // Operating modes
  typedef enum logic [2:0] {
    MMPC_MODE_SINGLE     = 3'h0,
    MMPC_MODE_PERIPHERAL = 3'h1,
    MMPC_MODE_EXPANDED   = 3'h2,
    MMPC_MODE_EMULATION  = 3'h3,
    MMPC_MODE_SPEC_TEST  = 3'h4,
    MMPC_MODE_SPEC_SC    = 3'h5
  } mmpc_mode_type;

  // Decoded map selects
  typedef struct packed {
    logic regs;
    logic ram;
    logic eeprom;
    logic flash;
    logic external;
  } mmpc_sel_type;

  // Effective map settings
  typedef struct packed {
    logic [4:0] ram_base;
    logic       ram_high_align;
    logic [3:0] reg_base;
    logic [4:0] ee_base;
    logic       ee_en;
    logic [1:0] stretch;
    logic       upper_only;
    logic       flash_en;
  } mmpc_map_type;

endpackage

// >>> verilog/mmpc_top.sv
`timescale 1ns/10ps
// Overview of operation
// - RAM position writes once, except special modes
// - Map changes two cycles after write
// - RAM position bits 7:3 give base 15:11
// - Alignment bit picks low or high end
// - Register block position writes once normally
// - Register block 1K/2K, 2K steps, low 32K
// - Register base four bits, top zero
// - EEPROM enable free; base lock chosen
// - EEPROM position bits 7:3 give base
// - EEPROM enable bit maps EEPROM in/out
// - Options reset: stretch 11, restriction 0
// - Option fields write once outside special
// - Stretch value gives 0..3 E-clocks
// - Stretch ignored in single-chip, peripheral
// - Upper-half bit blocks low fixed flash
// - Flash enable maps flash in/out
// - Test registers readable, writes ignored
// - RAM position resets to 0x09
// - Alignment places small RAM in region
module mmpc_top
  import mmpc_pkg::*;
#(
  parameter logic       EE_WRITE_ONCE  = 1'b0,
  parameter logic [7:0] EE_POS_RST     = 8'h00,
  parameter logic       FLASH_EXP_RST  = 1'b1,
  parameter int         RAM_REGION_LOG = 14,
  parameter int         RAM_SIZE_LOG   = 13
)(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic               wb_ack_o,
  input  wire mmpc_mode_type mode_i,
  input  wire logic          reg_size_2k_i,
  input  wire logic [15:0]   cpu_addr_i,
  output mmpc_sel_type       sel_o,
  output logic [1:0]         stretch_o,
  output mmpc_map_type       map_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Geometry outside one 64K map cannot be decoded
  if (RAM_REGION_LOG < 11 || RAM_REGION_LOG > 16 || RAM_SIZE_LOG > RAM_REGION_LOG)
  begin : g_bad_geometry
    $error("mmpc_top: unsupported RAM geometry");
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [7:0] ram_pos_q, ram_pos_d;
  logic [7:0] reg_pos_q, reg_pos_d;
  logic [7:0] ee_pos_q,  ee_pos_d;
  logic [7:0] sys_opt_q, sys_opt_d;
  logic       lk_ram_q, lk_reg_q, lk_ee_q, lk_opt_q;
  logic       rst_seen_q;
  logic       wb_ack_q;
  logic [31:0] rdat_q;

  wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  wire wr       = req & wb_we_i & wb_sel_i[0];
  wire hit_ram  = wb_adr_i == MMPC_OFS_RAM_POS;
  wire hit_reg  = wb_adr_i == MMPC_OFS_REG_POS;
  wire hit_ee   = wb_adr_i == MMPC_OFS_EE_POS;
  wire hit_opt  = wb_adr_i == MMPC_OFS_SYS_OPT;
  wire hit_ta   = wb_adr_i == MMPC_OFS_TEST_A;
  wire hit_tb   = wb_adr_i == MMPC_OFS_TEST_B;
  wire special  = (mode_i == MMPC_MODE_SPEC_TEST) | (mode_i == MMPC_MODE_SPEC_SC);
  wire no_ext   = (mode_i == MMPC_MODE_SINGLE) | (mode_i == MMPC_MODE_PERIPHERAL)
                | (mode_i == MMPC_MODE_SPEC_SC);
  wire [7:0] wd = wb_dat_i[7:0];

  // Write permission per register; locks only matter outside special modes
  wire ok_ram  = wr & hit_ram & (special | ~lk_ram_q);
  wire ok_reg  = wr & hit_reg & (special | ~lk_reg_q);
  wire ok_eeb  = wr & hit_ee & (special | ~EE_WRITE_ONCE | ~lk_ee_q);
  wire ok_een  = wr & hit_ee;
  wire ok_opt  = wr & hit_opt & (special | ~lk_opt_q);

  // Unimplemented bits stay zero; register base bit 7 is fixed zero
  assign ram_pos_d = ok_ram ? {wd[7:3], 2'h0, wd[0]} : ram_pos_q;
  assign reg_pos_d = ok_reg ? {1'b0, wd[6:3], 3'h0} : reg_pos_q;
  assign ee_pos_d  = {ok_eeb ? wd[7:3] : ee_pos_q[7:3], 2'h0,
                      ok_een ? wd[0] : ee_pos_q[0]};
  assign sys_opt_d = ok_opt ? {4'h0, wd[3:0]} : sys_opt_q;

  // Read mux; test registers read fixed values, writes ignored
  wire [7:0] rsel = hit_ram ? ram_pos_q :
                    hit_reg ? reg_pos_q :
                    hit_ee  ? ee_pos_q  :
                    hit_opt ? sys_opt_q :
                    hit_ta  ? MMPC_TEST_A_VAL :
                    hit_tb  ? MMPC_TEST_B_VAL : 8'h00;

  // Flash enable reset value by mode
  wire flash_rst = (mode_i == MMPC_MODE_SPEC_TEST) ? 1'b0 :
                   ((mode_i == MMPC_MODE_EXPANDED) | (mode_i == MMPC_MODE_EMULATION))
                   ? FLASH_EXP_RST : 1'b1;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Flash enable depends on mode pins, so it is caught just after reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ram_pos_q  <= MMPC_RAM_POS_RST;
      reg_pos_q  <= MMPC_REG_POS_RST;
      ee_pos_q   <= EE_POS_RST;
      sys_opt_q  <= {4'h0, MMPC_STR_RST, 2'h0};
      lk_ram_q   <= 1'b0;
      lk_reg_q   <= 1'b0;
      lk_ee_q    <= 1'b0;
      lk_opt_q   <= 1'b0;
      rst_seen_q <= 1'b0;
    end
    else
    begin
      ram_pos_q  <= ram_pos_d;
      reg_pos_q  <= reg_pos_d;
      ee_pos_q   <= ee_pos_d;
      sys_opt_q  <= rst_seen_q ? sys_opt_d : {sys_opt_d[7:1], flash_rst};
      lk_ram_q   <= lk_ram_q | (wr & hit_ram);
      lk_reg_q   <= lk_reg_q | (wr & hit_reg);
      lk_ee_q    <= lk_ee_q  | (wr & hit_ee);
      lk_opt_q   <= lk_opt_q | (wr & hit_opt);
      rst_seen_q <= 1'b1;
    end
  end

  // Single-cycle Wishbone answer: ack one clock after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_q <= 1'b0;
      rdat_q   <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= req;
      rdat_q   <= {24'h00_0000, rsel};
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Registered settings take effect the cycle after the write lands
  wire [4:0] ram_b  = ram_pos_q[MMPC_BASE_HI:MMPC_BASE_LO];
  wire       ram_hi = ram_pos_q[MMPC_BIT0];
  wire [3:0] reg_b  = reg_pos_q[6:3];
  wire [4:0] ee_b   = ee_pos_q[MMPC_BASE_HI:MMPC_BASE_LO];
  wire       ee_en  = ee_pos_q[MMPC_BIT0];
  wire [1:0] str    = sys_opt_q[MMPC_STR_HI:MMPC_STR_LO];
  wire       flash_upper_half_only  = sys_opt_q[MMPC_FLASH_UPPER_HALF_ONLY_BIT];
  wire       flash_map_enable  = sys_opt_q[MMPC_BIT0];

  localparam logic [15:0] REGION_MASK = 16'(~((17'h1 << RAM_REGION_LOG) - 17'h1));
  localparam logic [15:0] SIZE_SPAN   = 16'((17'h1 << RAM_SIZE_LOG) - 17'h1);
  localparam logic [15:0] GAP         = 16'((17'h1 << RAM_REGION_LOG)
                                          - (17'h1 << RAM_SIZE_LOG));

  // Small RAM sits at the low or high end of its region
  wire [15:0] ram_region = {ram_b, 11'h000} & REGION_MASK;
  wire [15:0] ram_start  = ram_region + (ram_hi ? GAP : 16'h0000);
  wire [15:0] ram_off    = cpu_addr_i - ram_start;
  wire in_ram   = ((cpu_addr_i & REGION_MASK) == ram_region) & (ram_off <= SIZE_SPAN);

  // Register block on any 2K boundary in the low 32K; 1K or 2K long
  wire in_reg   = (cpu_addr_i[15:11] == {1'b0, reg_b})
                & (reg_size_2k_i | ~cpu_addr_i[10]);
  wire in_ee    = ee_en & (cpu_addr_i[15:11] == ee_b);
  wire low_fix  = cpu_addr_i[15:14] == 2'h1;
  wire in_flash = flash_map_enable & (cpu_addr_i[15] | (low_fix & ~flash_upper_half_only));

  // Overlap priority
  mmpc_sel_type sel_d;
  assign sel_d.regs     = in_reg;
  assign sel_d.ram      = ~in_reg & in_ram;
  assign sel_d.eeprom   = ~in_reg & ~in_ram & in_ee;
  assign sel_d.flash    = ~in_reg & ~in_ram & ~in_ee & in_flash;
  assign sel_d.external = ~(in_reg | in_ram | in_ee | in_flash) & ~no_ext;

  // Stretch count in E-clocks, forced to zero without an external bus
  wire [1:0] str_d = no_ext ? 2'h0 : str;

  mmpc_map_type map_d;
  assign map_d = '{ram_base: ram_b, ram_high_align: ram_hi, reg_base: reg_b,
                   ee_base: ee_b, ee_en: ee_en, stretch: str,
                   upper_only: flash_upper_half_only, flash_en: flash_map_enable};

  // Outputs registered; decode is one cycle behind the address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_o     <= '0;
      stretch_o <= 2'h0;
      map_o     <= '0;
    end
    else
    begin
      sel_o     <= sel_d;
      stretch_o <= str_d;
      map_o     <= map_d;
    end
  end

endmodule

// >>> test/mmpc_chk.sv
`timescale 1ns/10ps
module mmpc_chk
  import mmpc_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_we_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  input wire mmpc_mode_type mode_i,
  input wire logic          reg_size_2k_i,
  input wire logic [15:0]   cpu_addr_i,
  input wire mmpc_sel_type  sel_o,
  input wire logic [1:0]    stretch_o,
  input wire mmpc_map_type  map_o
);
  // ---------------------------------------------------------------
  // Bus events and map checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Taken requests; quiet means no write could be in flight
  wire  taken  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire  wr     = taken && wb_we_i && wb_sel_i[0];
  wire  ram_wr = wr && (wb_adr_i == MMPC_OFS_RAM_POS);
  wire  spec   = (mode_i == MMPC_MODE_SPEC_TEST) || (mode_i == MMPC_MODE_SPEC_SC);
  wire  noext  = mode_i inside {MMPC_MODE_SINGLE, MMPC_MODE_PERIPHERAL, MMPC_MODE_SPEC_SC};
  logic ram_seen_q;
  // Any RAM position write arms its lock until reset
  always_ff @(posedge clk_i)
    ram_seen_q <= rst_i ? 1'b0 : (ram_seen_q | ram_wr);
  ram_map_a: assert property (ram_wr && spec |-> ##2
    map_o.ram_base == $past(wb_dat_i[7:3], 2) && map_o.ram_high_align == $past(wb_dat_i[0], 2))
    else $error("ram map not updated");
  ram_lock_a: assert property (ram_wr && !spec && ram_seen_q |->
    ##2 map_o.ram_base == $past(map_o.ram_base, 2)) else $error("ram lock broken");
  ee_en_a: assert property (wr && wb_adr_i == MMPC_OFS_EE_POS |->
    ##2 map_o.ee_en == $past(wb_dat_i[0], 2)) else $error("eeprom enable lost");
  ee_gate_a: assert property (!map_o.ee_en && !wb_cyc_i && !$past(wb_cyc_i) |=>
    !sel_o.eeprom) else $error("eeprom selected while off");
  reg_hit_a: assert property (!wb_cyc_i && !$past(wb_cyc_i) &&
    cpu_addr_i[15:11] == {1'b0, map_o.reg_base} && (reg_size_2k_i || !cpu_addr_i[10])
    |=> sel_o.regs && !sel_o.ram) else $error("register block missed");
  str_quiet_a: assert property (noext && $stable(mode_i) |-> stretch_o == 2'h0)
    else $error("stretch in no-bus mode");
  str_map_a: assert property (!noext && $stable(mode_i) && $stable(map_o.stretch) |->
    stretch_o == map_o.stretch) else $error("stretch mismatch");
  opt_reset_a: assert property ($fell(rst_i) |-> ##2 map_o.stretch == MMPC_STR_RST &&
    !map_o.upper_only) else $error("options reset wrong");
  test_read_a: assert property (taken && !wb_we_i && wb_adr_i == MMPC_OFS_TEST_A |=>
    wb_dat_o == {24'h0, MMPC_TEST_A_VAL}) else $error("test register read wrong");
  cover property (ram_wr && spec);
  cover property (sel_o.flash);
  cover property (sel_o.external);
endmodule
bind mmpc_top mmpc_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mode_i(mode_i),
  .reg_size_2k_i(reg_size_2k_i), .cpu_addr_i(cpu_addr_i), .sel_o(sel_o),
  .stretch_o(stretch_o), .map_o(map_o));

// >>> test/mmpc_cpu_model.sv
`timescale 1ns/10ps
module mmpc_cpu_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] addr_req_i,
  output logic      [15:0] cpu_addr_o
);
  // ---------------------------------------------------------------
  // Address phase
  // ---------------------------------------------------------------
  // Core launches one address per bus clock; parks at the top in reset
  always_ff @(posedge clk_i)
    cpu_addr_o <= rst_i ? 16'hFFFF : addr_req_i;
endmodule

// >>> test/mmpc_tb_top.sv
`timescale 1ns/10ps
module mmpc_tb_top;
  import mmpc_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          we = 1'b0, req = 1'b0, ack, r2k = 1'b1;
  logic [7:0]    adr = 8'h00;
  logic [31:0]   dat = 32'h0, rdat;
  logic [15:0]   areq = 16'hFFFF, caddr;
  logic [1:0]    str;
  mmpc_sel_type  sel;
  mmpc_map_type  map;
  logic [3:0]    bsel = 4'hF;
  mmpc_mode_type mode = MMPC_MODE_SINGLE;
  int            num_errors = 0, samples_checked = 0;
  // ---------------------------------------------------------------
  // Design, core model and scenarios
  // ---------------------------------------------------------------
  mmpc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(bsel), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_ack_o(ack), .mode_i(mode), .reg_size_2k_i(r2k), .cpu_addr_i(caddr),
    .sel_o(sel), .stretch_o(str), .map_o(map));
  mmpc_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .addr_req_i(areq), .cpu_addr_o(caddr));
  // 125 MHz bus clock
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle; ack is sampled at the rising edge, request released there
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    dat <= {24'h0, d};
    req <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, ack});
    r = rdat;
    req <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [31:0] r;
    wb(a, 1'b0, 8'h00, r);
    chk(nm, {24'h0, e}, r);
  endtask
  // Select is registered behind the core model, so allow it to settle
  task automatic dec(input logic [15:0] a, input logic k, input mmpc_sel_type e, input string nm);
    @(posedge clk_i);
    areq <= a;
    r2k <= k;
    repeat (3) @(posedge clk_i);
    #1;
    chk(nm, {27'h0, e}, {27'h0, sel});
  endtask
  task automatic t_reset();
    rd(MMPC_OFS_RAM_POS, 8'h09, "ram_position");
    rd(MMPC_OFS_REG_POS, 8'h00, "register_block_position");
    rd(MMPC_OFS_SYS_OPT, 8'h0D, "system_options");
    rd(MMPC_OFS_TEST_B, MMPC_TEST_B_VAL, "test_reserved_b");
    $display("reset values done");
  endtask
  // Single chip mode: second writes bounce off the locks, except the EEPROM position
  task automatic t_lock();
    wr(MMPC_OFS_RAM_POS, 8'hF9);
    wr(MMPC_OFS_RAM_POS, 8'h11);
    rd(MMPC_OFS_RAM_POS, 8'hF9, "ram_position");
    wr(MMPC_OFS_REG_POS, 8'hFF);
    wr(MMPC_OFS_REG_POS, 8'h08);
    rd(MMPC_OFS_REG_POS, 8'h78, "register_block_position");
    wr(MMPC_OFS_EE_POS, 8'h41);
    wr(MMPC_OFS_EE_POS, 8'h40);
    rd(MMPC_OFS_EE_POS, 8'h40, "eeprom_position");
    wr(MMPC_OFS_SYS_OPT, 8'h02);
    wr(MMPC_OFS_SYS_OPT, 8'h0D);
    rd(MMPC_OFS_SYS_OPT, 8'h02, "system_options");
    wr(MMPC_OFS_TEST_A, 8'hFF);
    rd(MMPC_OFS_TEST_A, MMPC_TEST_A_VAL, "test_reserved_a");
    rd(8'h40, 8'h00, "unmapped");
    $display("write locks done");
  endtask
  task automatic t_map();
    dec(16'h7FFF, 1'b1, 5'b10000, "regs 2k");
    dec(16'h7FFF, 1'b0, 5'b00000, "regs 1k");
    dec(16'hE000, 1'b1, 5'b01000, "ram high");
    dec(16'hC000, 1'b1, 5'b00000, "ram gap");
    chk("map reg_base", 32'hF, {28'h0, map.reg_base});
    $display("decode done");
  endtask
  // Special test mode: rewrites allowed, stretch table walked
  task automatic t_spec();
    @(posedge clk_i);
    mode <= MMPC_MODE_SPEC_TEST;
    wr(MMPC_OFS_RAM_POS, 8'h00);
    wr(MMPC_OFS_RAM_POS, 8'h01);
    dec(16'h2000, 1'b1, 5'b01000, "ram rewrite");
    @(posedge clk_i);
    bsel <= 4'hE;
    wr(MMPC_OFS_RAM_POS, 8'h08);
    @(posedge clk_i);
    bsel <= 4'hF;
    rd(MMPC_OFS_RAM_POS, 8'h01, "ram sel gate");
    wr(MMPC_OFS_SYS_OPT, 8'h09);
    dec(16'h4000, 1'b1, 5'b00010, "flash low");
    wr(MMPC_OFS_SYS_OPT, 8'h0B);
    dec(16'h4000, 1'b1, 5'b00001, "flash blocked");
    dec(16'h8000, 1'b1, 5'b00010, "flash upper");
    wr(MMPC_OFS_EE_POS, 8'h41);
    dec(16'h4000, 1'b1, 5'b00100, "eeprom on");
    wr(MMPC_OFS_EE_POS, 8'h21);
    dec(16'h2000, 1'b1, 5'b01000, "ram over eeprom");
    for (int s = 0; s < 4; s++)
    begin
      wr(MMPC_OFS_SYS_OPT, {4'h0, s[1:0], 2'b01});
      dec(16'h8000, 1'b1, 5'b00010, "flash on");
      chk("stretch", s, {30'h0, str});
    end
    @(posedge clk_i);
    mode <= MMPC_MODE_SPEC_SC;
    dec(16'h8000, 1'b1, 5'b00010, "flash spec sc");
    chk("stretch", 32'h0, {30'h0, str});
    $display("special mode done");
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence after 20 cycles of reset
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_lock();
    t_map();
    t_spec();
    complete_run();
  end
  // Watchdog: the whole run needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
endmodule
